// file: rtl/svs_pkg.sv
package svs_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [2:0] ADDR_ENABLE_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_COND_STATUS   = 3'h1;
    localparam logic [2:0] ADDR_IRQ_ENABLE    = 3'h2;
    localparam logic [2:0] ADDR_IRQ_FLAGS     = 3'h3;
    localparam logic [2:0] ADDR_RSVD_ZERO_LO  = 3'h4;
    localparam logic [2:0] ADDR_RSVD_ZERO_HI  = 3'h5;
    localparam logic [2:0] ADDR_RSVD_FACT_LO  = 3'h6;
    localparam logic [2:0] ADDR_RSVD_FACT_HI  = 3'h7;

    // sense_enable_config fields
    localparam int BIT_BATTERY_LEVEL = 0;
    localparam int BIT_BATTERY_ADC   = 1;
    localparam int BIT_SUPPLY_LEVEL  = 2;
    localparam int BIT_SUPPLY_ADC    = 3;
    localparam int BIT_LOW_SEL_LO    = 4;
    localparam int BIT_LOW_SEL_HI    = 5;
    localparam int BIT_HIGH_SEL      = 6;

    // status, irq enable and flag fields
    localparam int BIT_LOW_COND  = 0;
    localparam int BIT_HIGH_COND = 1;

    localparam logic [7:0] MASK_ENABLE_CONFIG = 8'h7F;
    localparam logic [7:0] MASK_COND_PAIR     = 8'h03;

    localparam logic [7:0] RESET_ENABLE_CONFIG = 8'h01;
    localparam logic [7:0] RESET_IRQ_ENABLE    = 8'h00;
    localparam logic [7:0] RESET_IRQ_FLAGS     = 8'h00;
    localparam logic [7:0] RESET_FACTORY       = 8'h00;
endpackage

// file: rtl/svs_supply_voltage_sense_ctrl.sv
// Functional notes
// - battery level or adc enable in run mode closes battery divider path
// - supply level or adc enable in run mode closes supply divider path
// - setting battery level enable clears supply level enable
// - supply level enable cannot be set while battery level enable set; the code still sets it in a write that clears battery level enable
// - setting battery adc enable clears supply adc enable
// - supply adc enable cannot be set while battery adc enable set; the code still sets it in a write that clears battery adc enable
// - adc enable routes its pin to adc channel, else channel disconnected
// - comparator source and adc source are selected independently
// - stop mode opens battery divider path and disables level sensing
// - stop mode opens supply divider path and disables level sensing
// - configuration registers keep their contents across stop mode
// - bit 6 picks high trigger level, 0 first, 1 second
// - bits 5:4 pick one of four low trigger levels in order
// - registers sit at base plus offset, main four at 0x0 to 0x3
// - unimplemented bits read back as zero
// - condition status forced to zero when both level enables are clear
// - flag sets on any status change, stays until software writes one
// - single interrupt requested when an enabled flag is set
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module svs_supply_voltage_sense_ctrl
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       stop_mode,
    input  wire logic       special_mode,
    input  wire logic       cmp_high_raw,
    input  wire logic       cmp_low_raw,
    output logic            battery_path_closed,
    output logic            supply_path_closed,
    output logic            cmp_enable,
    output logic            cmp_source_supply,
    output logic            adc_connect_battery,
    output logic            adc_connect_supply,
    output logic            high_threshold_select,
    output logic      [1:0] low_threshold_select,
    output logic            irq
);

    logic [7:0] sense_enable_config;
    logic [1:0] sense_interrupt_enable;
    logic [1:0] sense_interrupt_flags;
    logic [7:0] factory_lo;
    logic [7:0] factory_hi;
    logic [1:0] cmp_meta;
    logic [1:0] cmp_sync;
    logic [1:0] sense_condition_status;
    logic [7:0] next_enable_config;
    logic [1:0] next_status;
    logic [1:0] status_change;
    logic       battery_level_enable;
    logic       supply_level_enable;
    logic       battery_adc_enable;
    logic       supply_adc_enable;
    logic       level_active;

    // next values of the registered outputs
    logic       next_battery_path;
    logic       next_supply_path;
    logic       next_adc_battery;
    logic       next_adc_supply;
    logic       next_cmp_source;
    logic       next_irq;
    logic [1:0] next_flags;
    logic [7:0] next_rdata;

    // one write decode shared by every writable register
    function automatic logic wr_hit(input logic [2:0] a);
        wr_hit = wr_en && (addr == a);
    endfunction

    // every analog path opens in stop mode, whatever the register holds
    function automatic logic run_only(input logic request, input logic stopped);
        run_only = request && !stopped;
    endfunction

    // status, enable and flag registers keep two live bits in an 8-bit slot
    function automatic logic [7:0] pad_pair(input logic [1:0] pair);
        pad_pair = {6'h00, pair};
    endfunction

    assign battery_level_enable = sense_enable_config[svs_pkg::BIT_BATTERY_LEVEL];
    assign supply_level_enable  = sense_enable_config[svs_pkg::BIT_SUPPLY_LEVEL];
    assign battery_adc_enable   = sense_enable_config[svs_pkg::BIT_BATTERY_ADC];
    assign supply_adc_enable    = sense_enable_config[svs_pkg::BIT_SUPPLY_ADC];
    assign level_active = run_only(battery_level_enable || supply_level_enable, stop_mode);

    // the register bits stay as written; of these derived controls only the path and adc ones see stop mode
    assign next_battery_path = run_only(battery_level_enable || battery_adc_enable, stop_mode);
    assign next_supply_path  = run_only(supply_level_enable || supply_adc_enable, stop_mode);
    assign next_adc_battery  = run_only(battery_adc_enable, stop_mode);
    assign next_adc_supply   = run_only(supply_adc_enable, stop_mode);
    assign next_cmp_source   = !battery_level_enable && supply_level_enable;
    assign next_irq          = |(sense_interrupt_flags & sense_interrupt_enable);

    // battery bits win: a write that sets one clears its supply partner, and a
    // supply bit written while the battery bit stays set is dropped
    // a write that clears a battery bit may still raise its supply twin at once
    always_comb
    begin
        next_enable_config = wdata & svs_pkg::MASK_ENABLE_CONFIG;
        if (wdata[svs_pkg::BIT_BATTERY_LEVEL])
        begin
            next_enable_config[svs_pkg::BIT_SUPPLY_LEVEL] = 1'b0;
        end
        if (wdata[svs_pkg::BIT_BATTERY_ADC])
        begin
            next_enable_config[svs_pkg::BIT_SUPPLY_ADC] = 1'b0;
        end
    end

    // stop mode does not touch the register, only the derived outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sense_enable_config <= svs_pkg::RESET_ENABLE_CONFIG;
        end
        else if (wr_hit(svs_pkg::ADDR_ENABLE_CONFIG))
        begin
            sense_enable_config <= next_enable_config;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sense_interrupt_enable <= svs_pkg::RESET_IRQ_ENABLE[1:0];
        end
        else if (wr_hit(svs_pkg::ADDR_IRQ_ENABLE))
        begin
            sense_interrupt_enable <= wdata[1:0];
        end
    end

    // factory test pair: writable only in special mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            factory_lo <= svs_pkg::RESET_FACTORY;
        end
        else if (special_mode && wr_hit(svs_pkg::ADDR_RSVD_FACT_LO))
        begin
            factory_lo <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            factory_hi <= svs_pkg::RESET_FACTORY;
        end
        else if (special_mode && wr_hit(svs_pkg::ADDR_RSVD_FACT_HI))
        begin
            factory_hi <= wdata;
        end
    end

    // two-flop synchroniser on the analog comparator outputs
    // nothing but cmp_sync reads cmp_meta, which may still be metastable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_meta <= 2'h0;
        end
        else
        begin
            cmp_meta <= {cmp_high_raw, cmp_low_raw};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_sync <= 2'h0;
        end
        else
        begin
            cmp_sync <= cmp_meta;
        end
    end

    // disabling the comparator during a live condition yields one more flag event
    // status moves only on synchronised samples, never on the raw pins
    assign next_status   = level_active ? cmp_sync : 2'h0;
    assign status_change = next_status ^ sense_condition_status;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sense_condition_status <= 2'h0;
        end
        else
        begin
            sense_condition_status <= next_status;
        end
    end

    // a change in the same cycle as a clearing write keeps the flag set
    always_comb
    begin
        next_flags = sense_interrupt_flags;
        if (wr_hit(svs_pkg::ADDR_IRQ_FLAGS))
        begin
            next_flags = next_flags & ~wdata[1:0];
        end
        next_flags = next_flags | status_change;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sense_interrupt_flags <= svs_pkg::RESET_IRQ_FLAGS[1:0];
        end
        else
        begin
            sense_interrupt_flags <= next_flags;
        end
    end

    // irq trails its flag by one clock so that it leaves a flop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    // each analog switch has a flop of its own so that it never glitches
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            battery_path_closed <= 1'b0;
        end
        else
        begin
            battery_path_closed <= next_battery_path;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            supply_path_closed <= 1'b0;
        end
        else
        begin
            supply_path_closed <= next_supply_path;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            adc_connect_battery <= 1'b0;
        end
        else
        begin
            adc_connect_battery <= next_adc_battery;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            adc_connect_supply <= 1'b0;
        end
        else
        begin
            adc_connect_supply <= next_adc_supply;
        end
    end

    // stop mode drops the comparator but keeps the enable bits for the exit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_enable <= 1'b0;
        end
        else
        begin
            cmp_enable <= level_active;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_source_supply <= 1'b0;
        end
        else
        begin
            cmp_source_supply <= next_cmp_source;
        end
    end

    // trigger selects follow the register one clock late, like every other output
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            high_threshold_select <= 1'b0;
        end
        else
        begin
            high_threshold_select <= sense_enable_config[svs_pkg::BIT_HIGH_SEL];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            low_threshold_select <= 2'h0;
        end
        else
        begin
            low_threshold_select <= sense_enable_config[svs_pkg::BIT_LOW_SEL_HI:
                                                        svs_pkg::BIT_LOW_SEL_LO];
        end
    end

    // read data valid only in the cycle after the read strobe
    always_comb
    begin
        next_rdata = 8'h00;
        if (rd_en)
        begin
            case (addr)
                svs_pkg::ADDR_ENABLE_CONFIG: next_rdata = sense_enable_config;
                svs_pkg::ADDR_COND_STATUS:   next_rdata = pad_pair(sense_condition_status);
                svs_pkg::ADDR_IRQ_ENABLE:    next_rdata = pad_pair(sense_interrupt_enable);
                svs_pkg::ADDR_IRQ_FLAGS:     next_rdata = pad_pair(sense_interrupt_flags);
                svs_pkg::ADDR_RSVD_FACT_LO:  next_rdata = factory_lo;
                svs_pkg::ADDR_RSVD_FACT_HI:  next_rdata = factory_hi;
                default:                     next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

endmodule

// file: sim/svs_analog_model.sv
`timescale 1ns/1ps
module svs_analog_model
#(
    parameter int HI_BASE = 16000,
    parameter int HI_STEP = 1000,
    parameter int LO_BASE = 5500,
    parameter int LO_STEP = 500
)
(
    input  logic       battery_path_closed,
    input  logic       supply_path_closed,
    input  logic       cmp_enable,
    input  logic       cmp_source_supply,
    input  logic       adc_connect_battery,
    input  logic       adc_connect_supply,
    input  logic       high_threshold_select,
    input  logic [1:0] low_threshold_select,
    input  int         vbat_mv,
    input  int         chip_supply_pin_mv,
    output logic       cmp_high_raw,
    output logic       cmp_low_raw,
    output int         adc_mv
);
    int v;
    // an open divider leaves the comparator input at ground
    assign v = cmp_source_supply ? (supply_path_closed ? chip_supply_pin_mv : 0)
                                 : (battery_path_closed ? vbat_mv : 0);
    // an unpowered comparator drives low
    assign cmp_high_raw = cmp_enable && v >= HI_BASE + HI_STEP * int'(high_threshold_select);
    assign cmp_low_raw  = cmp_enable && v < LO_BASE + LO_STEP * int'(low_threshold_select);
    // -1 marks a disconnected channel
    assign adc_mv = adc_connect_battery ? vbat_mv : adc_connect_supply ? chip_supply_pin_mv : -1;
endmodule

// file: sim/svs_sense_ctrl_asserts.sv
`timescale 1ns/1ps
module svs_sense_checker
(
    input logic       clk,
    input logic       rst,
    input logic [2:0] addr,
    input logic [7:0] wdata,
    input logic       wr_en,
    input logic       rd_en,
    input logic [7:0] rdata,
    input logic       stop_mode,
    input logic       battery_path_closed,
    input logic       supply_path_closed,
    input logic       cmp_enable,
    input logic       cmp_source_supply,
    input logic       adc_connect_battery,
    input logic       adc_connect_supply,
    input logic       high_threshold_select,
    input logic [1:0] low_threshold_select,
    input logic       irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire cfg_wr = wr_en && addr == 3'h0;
    a_stop_battery_open: assert property (stop_mode |=> !battery_path_closed)
        else $error("battery path closed in stop");
    a_stop_supply_open: assert property (stop_mode |=> !supply_path_closed && !cmp_enable)
        else $error("supply path or comparator on in stop");
    a_adc_one_pin: assert property (!(adc_connect_battery && adc_connect_supply))
        else $error("both pins on adc");
    a_cmp_path_closed: assert property (cmp_enable |->
        (cmp_source_supply ? supply_path_closed : battery_path_closed))
        else $error("comparator pin path open");
    a_adc_path_closed: assert property (!(adc_connect_battery && !battery_path_closed)
        && !(adc_connect_supply && !supply_path_closed))
        else $error("adc pin path open");
    a_level_battery_wins: assert property (cfg_wr && wdata[0] ##1 !stop_mode |=>
        cmp_enable && !cmp_source_supply && battery_path_closed)
        else $error("battery level enable lost");
    a_adc_battery_wins: assert property (cfg_wr && wdata[1] ##1 !stop_mode |=>
        adc_connect_battery && !adc_connect_supply)
        else $error("battery adc enable lost");
    a_threshold_follow: assert property (cfg_wr |-> ##2 high_threshold_select ==
        $past(wdata[6], 2) && low_threshold_select == $past(wdata[5:4], 2))
        else $error("threshold select wrong");
    a_unused_bits_zero: assert property ($past(rd_en) && $past(addr) != 3'h0
        && $past(addr) < 3'h6 |-> rdata[7:2] == 6'h00)
        else $error("unused bits not zero");
    a_status_forced: assert property ((!cmp_enable) [*4] ##1 (rd_en && addr == 3'h1
        && !cmp_enable) |=> rdata[1:0] == 2'h0)
        else $error("status not forced low");
    c_irq: cover property (irq);
    c_stop_exit: cover property (stop_mode ##1 !stop_mode);
    c_split_sources: cover property (cmp_enable && cmp_source_supply && adc_connect_battery);
endmodule
bind svs_supply_voltage_sense_ctrl svs_sense_checker i_svs_sense_checker
(
    .clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .stop_mode, .battery_path_closed,
    .supply_path_closed, .cmp_enable, .cmp_source_supply, .adc_connect_battery,
    .adc_connect_supply, .high_threshold_select, .low_threshold_select, .irq
);

// file: sim/svs_supply_voltage_sense_ctrl_tb_top.sv
`timescale 1ns/1ps
module svs_supply_voltage_sense_ctrl_tb_top;
    localparam int HI_BASE = 16000;
    localparam int HI_STEP = 1000;
    localparam int LO_BASE = 5500;
    localparam int LO_STEP = 500;
    logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic        stop_mode = 1'b0, special_mode = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, rdata, d, cfg = 8'h01, ien = 8'h00, flg = 8'h00;
    logic [7:0]  fac [2] = '{8'h00, 8'h00};
    logic [1:0]  st = 2'h0, low_threshold_select;
    logic        cmp_high_raw, cmp_low_raw, battery_path_closed, supply_path_closed, irq;
    logic        cmp_enable, cmp_source_supply, adc_connect_battery, adc_connect_supply;
    logic        high_threshold_select;
    int          vbat_mv = 12000, chip_supply_pin_mv = 12000, adc_mv, mismatches = 0, total_checks = 0;
    logic [31:0] seed = 32'h00008C95;
    svs_supply_voltage_sense_ctrl i_svs_supply_voltage_sense_ctrl
    (
        .clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .stop_mode, .special_mode,
        .cmp_high_raw, .cmp_low_raw, .battery_path_closed, .supply_path_closed, .cmp_enable,
        .cmp_source_supply, .adc_connect_battery, .adc_connect_supply,
        .high_threshold_select, .low_threshold_select, .irq
    );
    svs_analog_model #(.HI_BASE(HI_BASE), .HI_STEP(HI_STEP), .LO_BASE(LO_BASE),
        .LO_STEP(LO_STEP)) i_svs_analog_model
    (
        .battery_path_closed, .supply_path_closed, .cmp_enable, .cmp_source_supply,
        .adc_connect_battery, .adc_connect_supply, .high_threshold_select,
        .low_threshold_select, .vbat_mv, .chip_supply_pin_mv, .cmp_high_raw, .cmp_low_raw, .adc_mv
    );
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic put(logic [2:0] a, logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        if (a == 3'h0) cfg = v & 8'h7F & ~{4'h0, v[1], v[0], 2'h0};
        if (a == 3'h2) ien = v & 8'h03;
        if (a == 3'h3) flg = flg & ~v;
        if (a[2:1] == 2'h3 && special_mode) fac[a[0]] = v;
    endtask
    task automatic check_all();
        logic [7:0] exp [8];
        logic       on;
        exp = '{cfg, {6'h00, st}, ien, flg, 8'h00, 8'h00, fac[0], fac[1]};
        on = !stop_mode && (cfg[0] || cfg[2]);
        for (int a = 0; a < 8; a++)
        begin
            @(posedge clk);
            addr <= 3'(a);
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1 chk("register", rdata, exp[a]);
        end
        chk("ports", {battery_path_closed, supply_path_closed, cmp_enable, adc_connect_battery,
            adc_connect_supply, cmp_source_supply & cmp_enable, high_threshold_select,
            low_threshold_select, irq}, {!stop_mode & (cfg[0] | cfg[1]),
            !stop_mode & (cfg[2] | cfg[3]), on, !stop_mode & cfg[1], !stop_mode & cfg[3],
            on & cfg[2], cfg[6], cfg[5:4], |(flg & ien)});
        chk("adc", adc_mv, !stop_mode && cfg[1] ? vbat_mv :
            !stop_mode && cfg[3] ? chip_supply_pin_mv : -1);
    endtask
    task automatic step();
        logic [1:0] ns;
        int         v;
        repeat (8) @(posedge clk);
        v = cfg[0] ? vbat_mv : chip_supply_pin_mv;
        ns = 2'h0;
        if (!stop_mode && (cfg[0] || cfg[2]))
            ns = {v >= HI_BASE + HI_STEP * int'(cfg[6]), v < LO_BASE + LO_STEP * int'(cfg[5:4])};
        flg = flg | {6'h00, ns ^ st};
        st = ns;
        check_all();
    endtask
    initial
    begin
        forever #10 clk = ~clk;
    end
    initial
    begin
        logic [31:0] r;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        check_all();
        for (int i = 0; i < 160; i++)
        begin
            r = rnd();
            d = r[15:8];
            @(posedge clk);
            case (r[2:0])
                3'h0:
                begin
                    // keep out a write that drops a battery enable and raises its twin
                    if (cfg[0] && !d[0]) d[2] = 1'b0;
                    if (cfg[1] && !d[1]) d[3] = 1'b0;
                    put(3'h0, d);
                end
                3'h1: put(3'h2, d);
                3'h2: put(3'h3, d);
                3'h3:
                begin
                    vbat_mv <= 4000 + int'(r[31:16] % 16000);
                    chip_supply_pin_mv <= 4000 + int'(r[29:14] % 16000);
                end
                3'h4: stop_mode <= !stop_mode;
                default:
                begin
                    special_mode <= r[3];
                    put(r[2:0] == 3'h5 ? 3'h1 : {1'b1, r[5:4]}, d);
                end
            endcase
            step();
        end
        close_out();
    end
endmodule
